/* rtl/audio_rx_tx_fifo_slot_control.sv */
// Receive/transmit FIFOs, slot enables and per-slot DMA registers.
// Assumes a synchronous processor port and a codec that makes the bit clock.
`timescale 1ns/1ps
`default_nettype none
module audio_rx_tx_fifo_slot_control #(
  parameter int DATA_W = audio_pkg::DATA_W,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire audio_pkg::cpu_req_t cpu_req_in,
  output logic [15:0] cpu_rdata_out,
  input wire logic bit_clk_in,
  input wire logic frame_sync_in,
  input wire logic serial_rx_in,
  output logic serial_transmit_output_out,
  output logic serial_transmit_oe_n_out,
  output logic rx_irq_out,
  output logic rx_err_irq_out,
  output logic tx_irq_out,
  output logic [3:0] rx_dma_req_out,
  output logic [3:0] tx_dma_req_out
);
  localparam int PW = audio_pkg::PTR_W;
  localparam int CW = audio_pkg::CNT_W;

  ////////////////////////////////////////////////////////////////////////////
  // Register state.

  logic audio_module_enable_q, rx_error_irq_enable_q;
  logic [1:0] last_slot_q;
  logic [3:0] rx_dma_request_mask_q, tx_dma_mask_q;
  logic [3:0] rx_slot_enables_q, rx_slot_dma_select_q, rx_warning_level_q;
  logic [3:0] tx_slot_enables_q, tx_slot_dma_select_q, tx_warning_level_q;
  logic rx_overflow_flag_q, tx_underrun_flag_q;
  logic [DATA_W-1:0] rx_mem [DEPTH];
  logic [DATA_W-1:0] tx_mem [DEPTH];
  logic [PW-1:0] rx_write_pointer_q, rx_read_pointer_q;
  logic [PW-1:0] tx_write_pointer_q, tx_read_pointer_q;
  logic rx_lastw_q, tx_lastw_q;
  logic [3:0][15:0] rx_slot_dma_data_q, tx_slot_dma_data_q, tx_stage_q;
  logic [3:0] rx_dma_full_q, tx_dma_empty_q;
  logic [15:0] rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Link engine and event crossings.

  logic rx_tog, tx_tog;
  audio_pkg::slot_word_t rx_word;
  logic [1:0] tx_slot;
  logic rx_meta_q, rx_sync_q, rx_seen_q;
  logic tx_meta_q, tx_sync_q, tx_seen_q;

  audio_link u_link (
    .bit_clk_in(bit_clk_in),
    .rstn_in(rstn_in),
    .frame_sync_in(frame_sync_in),
    .serial_rx_in(serial_rx_in),
    .rx_slot_en_in(rx_slot_enables_q & {4{audio_module_enable_q}}),
    .tx_slot_en_in(tx_slot_enables_q & {4{audio_module_enable_q}}),
    .last_slot_in(last_slot_q),
    .tx_stage_in(tx_stage_q),
    .rx_toggle_out(rx_tog),
    .rx_word_out(rx_word),
    .tx_toggle_out(tx_tog),
    .tx_slot_out(tx_slot),
    .serial_tx_out(serial_transmit_output_out),
    .serial_tx_oe_n_out(serial_transmit_oe_n_out)
  );

  // Words stay stable in the link for a whole slot after each toggle.
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      {rx_meta_q, rx_sync_q, rx_seen_q} <= 3'b000;
      {tx_meta_q, tx_sync_q, tx_seen_q} <= 3'b000;
    end else begin
      {rx_meta_q, rx_sync_q, rx_seen_q} <= {rx_tog, rx_meta_q, rx_sync_q};
      {tx_meta_q, tx_sync_q, tx_seen_q} <= {tx_tog, tx_meta_q, tx_sync_q};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode, flags and transfer conditions.

  logic wr, rd;
  logic [15:0] wd;
  logic [3:0] ad;
  logic rx_evt, tx_evt, rx_dma_hit, rx_push_req, rx_push, rx_pop;
  logic tx_src, tx_pop, tx_under, tx_take, tx_push;
  logic [CW-1:0] rx_count, tx_count;
  logic rx_full, rx_empty, rx_af, tx_full, tx_empty, tx_ae;
  logic [DATA_W-1:0] tx_prev_word;
  logic [1:0] rs;

  always_comb begin
    wr = cpu_req_in.wr;
    rd = cpu_req_in.rd;
    wd = cpu_req_in.wdata;
    ad = cpu_req_in.addr;
    rs = rx_word.slot;
    rx_count = audio_pkg::fifo_count(rx_write_pointer_q, rx_read_pointer_q, rx_lastw_q);
    tx_count = audio_pkg::fifo_count(tx_write_pointer_q, tx_read_pointer_q, tx_lastw_q);
    rx_full = (rx_write_pointer_q == rx_read_pointer_q) && rx_lastw_q;
    rx_empty = (rx_write_pointer_q == rx_read_pointer_q) && !rx_lastw_q;
    rx_af = (rx_count == {1'b0, rx_warning_level_q}) && (rx_count != '0);
    tx_full = (tx_write_pointer_q == tx_read_pointer_q) && tx_lastw_q;
    tx_empty = (tx_write_pointer_q == tx_read_pointer_q) && !tx_lastw_q;
    tx_ae = tx_count <= {1'b0, tx_warning_level_q};
    rx_evt = rx_sync_q ^ rx_seen_q;
    tx_evt = tx_sync_q ^ tx_seen_q;
    rx_dma_hit = rx_evt && audio_module_enable_q && rx_slot_enables_q[rs]
                 && rx_slot_dma_select_q[rs];
    rx_push_req = rx_evt && audio_module_enable_q && rx_slot_enables_q[rs]
                  && !rx_slot_dma_select_q[rs];
    rx_push = rx_push_req && !rx_full;
    rx_pop = rd && (ad == audio_pkg::ADDR_RX_DATA) && !rx_empty;
    tx_src = tx_evt && audio_module_enable_q && tx_slot_enables_q[tx_slot]
             && !tx_slot_dma_select_q[tx_slot];
    tx_take = tx_evt && audio_module_enable_q && tx_slot_enables_q[tx_slot]
              && tx_slot_dma_select_q[tx_slot];
    tx_pop = tx_src && !tx_empty;
    tx_under = tx_src && tx_empty;
    tx_push = wr && (ad == audio_pkg::ADDR_TX_DATA) && !tx_full;
    tx_prev_word = tx_mem[PW'(tx_read_pointer_q - 1'b1)];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers.

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      audio_module_enable_q <= 1'b0;
      rx_error_irq_enable_q <= 1'b0;
      last_slot_q <= 2'b00;
      rx_dma_request_mask_q <= 4'h0;
      tx_dma_mask_q <= 4'h0;
    end else if (wr && ad == audio_pkg::ADDR_GLOBAL) begin
      audio_module_enable_q <= wd[audio_pkg::GLB_EN_BIT];
      rx_error_irq_enable_q <= wd[audio_pkg::GLB_ERRIE_BIT];
      last_slot_q <= wd[audio_pkg::GLB_LAST_SLOT_LSB +: 2];
    end else if (wr && ad == audio_pkg::ADDR_DMA_MASK) begin
      rx_dma_request_mask_q <= wd[3:0];
      tx_dma_mask_q <= wd[audio_pkg::MASK_TX_LSB +: 4];
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_slot_enables_q <= audio_pkg::RX_SC_RESET[audio_pkg::SLOT_EN_LSB +: 4];
      rx_slot_dma_select_q <= audio_pkg::RX_SC_RESET[audio_pkg::DMA_SEL_LSB +: 4];
      rx_warning_level_q <= audio_pkg::RX_WARN_RESET;
    end else if (wr && ad == audio_pkg::ADDR_RX_SC) begin
      rx_slot_enables_q <= wd[audio_pkg::SLOT_EN_LSB +: 4];
      rx_slot_dma_select_q <= wd[audio_pkg::DMA_SEL_LSB +: 4];
      rx_warning_level_q <= wd[audio_pkg::WARN_LSB +: 4];
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx_slot_enables_q <= audio_pkg::TX_SC_RESET[audio_pkg::SLOT_EN_LSB +: 4];
      tx_slot_dma_select_q <= audio_pkg::TX_SC_RESET[audio_pkg::DMA_SEL_LSB +: 4];
      tx_warning_level_q <= audio_pkg::TX_WARN_RESET;
    end else if (wr && ad == audio_pkg::ADDR_TX_SC) begin
      tx_slot_enables_q <= wd[audio_pkg::SLOT_EN_LSB +: 4];
      tx_slot_dma_select_q <= wd[audio_pkg::DMA_SEL_LSB +: 4];
      tx_warning_level_q <= wd[audio_pkg::WARN_LSB +: 4];
    end
  end

  // Sticky error flags clear on a written one; a new event wins the cycle.
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_overflow_flag_q <= 1'b0;
      tx_underrun_flag_q <= 1'b0;
    end else begin
      if (rx_push_req && rx_full) begin
        rx_overflow_flag_q <= 1'b1;
      end else if (wr && ad == audio_pkg::ADDR_RX_SC && wd[audio_pkg::STICKY_BIT]) begin
        rx_overflow_flag_q <= 1'b0;
      end
      if (tx_under) begin
        tx_underrun_flag_q <= 1'b1;
      end else if (wr && ad == audio_pkg::ADDR_TX_SC && wd[audio_pkg::STICKY_BIT]) begin
        tx_underrun_flag_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive FIFO.

  always_ff @(posedge ref_clk_in) begin
    if (rx_push) begin
      rx_mem[rx_write_pointer_q] <= rx_word.data;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_write_pointer_q <= '0;
      rx_read_pointer_q <= '0;
      rx_lastw_q <= 1'b0;
    end else begin
      if (rx_push) begin
        rx_write_pointer_q <= PW'(rx_write_pointer_q + 1'b1);
      end
      if (rx_pop) begin
        rx_read_pointer_q <= PW'(rx_read_pointer_q + 1'b1);
      end
      if (rx_push != rx_pop) begin
        rx_lastw_q <= rx_push;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit FIFO and slot staging.

  always_ff @(posedge ref_clk_in) begin
    if (tx_push) begin
      tx_mem[tx_write_pointer_q] <= wd;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx_write_pointer_q <= '0;
      tx_read_pointer_q <= '0;
      tx_lastw_q <= 1'b0;
    end else begin
      if (tx_push) begin
        tx_write_pointer_q <= PW'(tx_write_pointer_q + 1'b1);
      end
      if (tx_pop) begin
        tx_read_pointer_q <= PW'(tx_read_pointer_q + 1'b1);
      end
      if (tx_push != tx_pop) begin
        tx_lastw_q <= tx_push;
      end
    end
  end

  // Each slot word is staged right after the link takes the previous one.
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx_stage_q <= '0;
    end else if (tx_pop) begin
      tx_stage_q[tx_slot] <= tx_mem[tx_read_pointer_q];
    end else if (tx_under) begin
      tx_stage_q[tx_slot] <= tx_prev_word;
    end else if (tx_take) begin
      if (wr && ad == (audio_pkg::ADDR_TX_DMA_BASE | {2'b00, tx_slot})) begin
        tx_stage_q[tx_slot] <= wd;
      end else begin
        tx_stage_q[tx_slot] <= tx_slot_dma_data_q[tx_slot];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-slot DMA data registers.

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_slot_dma_data_q <= '0;
      rx_dma_full_q <= 4'h0;
    end else begin
      for (int n = 0; n < audio_pkg::SLOTS; n++) begin
        if (rx_dma_hit && rs == 2'(n)) begin
          rx_slot_dma_data_q[n] <= rx_word.data;
          rx_dma_full_q[n] <= 1'b1;
        end else if (rd && ad == (audio_pkg::ADDR_RX_DMA_BASE | 4'(n))) begin
          rx_dma_full_q[n] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx_slot_dma_data_q <= '0;
      tx_dma_empty_q <= 4'hF;
    end else begin
      for (int n = 0; n < audio_pkg::SLOTS; n++) begin
        if (wr && ad == (audio_pkg::ADDR_TX_DMA_BASE | 4'(n))) begin
          tx_slot_dma_data_q[n] <= wd;
        end
        if (tx_take && tx_slot == 2'(n)) begin
          tx_dma_empty_q[n] <= 1'b1;
        end else if (wr && ad == (audio_pkg::ADDR_TX_DMA_BASE | 4'(n))) begin
          tx_dma_empty_q[n] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port and request outputs.

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_q <= 16'h0000;
    end else if (rd) begin
      unique case (ad)
        audio_pkg::ADDR_GLOBAL: rdata_q <= {12'h000, last_slot_q,
                                            rx_error_irq_enable_q, audio_module_enable_q};
        audio_pkg::ADDR_RX_SC: rdata_q <= {rx_warning_level_q, rx_slot_dma_select_q,
                                           rx_slot_enables_q, rx_overflow_flag_q,
                                           rx_empty, rx_full, rx_af};
        audio_pkg::ADDR_TX_SC: rdata_q <= {tx_warning_level_q, tx_slot_dma_select_q,
                                           tx_slot_enables_q, tx_underrun_flag_q,
                                           tx_full, tx_empty, tx_ae};
        audio_pkg::ADDR_RX_DATA: rdata_q <= rx_mem[rx_read_pointer_q];
        audio_pkg::ADDR_DMA_MASK: rdata_q <= {8'h00, tx_dma_mask_q, rx_dma_request_mask_q};
        4'h8, 4'h9, 4'hA, 4'hB: rdata_q <= rx_slot_dma_data_q[ad[1:0]];
        4'hC, 4'hD, 4'hE, 4'hF: rdata_q <= tx_slot_dma_data_q[ad[1:0]];
        default: rdata_q <= 16'h0000;
      endcase
    end
  end

  assign cpu_rdata_out = rdata_q;
  assign rx_irq_out = rx_count > {1'b0, rx_warning_level_q};
  assign tx_irq_out = tx_ae;
  assign rx_err_irq_out = rx_overflow_flag_q && rx_error_irq_enable_q;
  assign rx_dma_req_out = rx_dma_full_q & rx_dma_request_mask_q
                          & rx_slot_dma_select_q & rx_slot_enables_q;
  assign tx_dma_req_out = tx_dma_empty_q & tx_dma_mask_q
                          & tx_slot_dma_select_q & tx_slot_enables_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);

  a_rx_overflow_drop: assert property (
    rx_push_req && rx_full |=> rx_overflow_flag_q && $stable(rx_write_pointer_q))
    else $error("overflowed word was not dropped");
  a_rx_fill_full: assert property (
    rx_push && !rx_pop && rx_count == audio_pkg::CNT_NEAR_FULL |=> rx_full && !rx_empty)
    else $error("receive full not flagged");
  a_rx_drain_empty: assert property (
    rx_pop && !rx_push && rx_count == audio_pkg::CNT_ONE |=> rx_empty && !rx_full)
    else $error("receive empty not flagged");
  a_rx_dma_bypass: assert property (
    rx_dma_hit |=> rx_dma_full_q[$past(rs)] && $stable(rx_write_pointer_q))
    else $error("dma slot word went astray");
  a_rx_slot_gate: assert property (
    rx_push |-> rx_slot_enables_q[rs] && audio_module_enable_q && rs <= last_slot_q)
    else $error("word accepted from disabled slot");
  a_rx_err_irq: assert property (
    $rose(rx_overflow_flag_q) && rx_error_irq_enable_q |-> rx_err_irq_out)
    else $error("receive error interrupt missing");
  a_tx_underrun_resend: assert property (
    tx_under |=> tx_underrun_flag_q && $stable(tx_read_pointer_q)
                 && tx_stage_q[$past(tx_slot)] == $past(tx_prev_word))
    else $error("underrun did not resend previous word");
  a_tx_write_full: assert property (
    tx_push && !tx_pop && tx_count == audio_pkg::CNT_NEAR_FULL |=> tx_full)
    else $error("transmit full not flagged");
  a_tx_read_empty: assert property (
    tx_pop && !tx_push && tx_count == audio_pkg::CNT_ONE |=> tx_empty && tx_irq_out)
    else $error("transmit empty not flagged");
endmodule
`default_nettype wire

/* shared/audio_pkg.sv */
// Shared constants, carriers and helpers for the audio slot FIFO block.
// Assumes a 16-bit processor register port and a codec-driven bit clock.
package audio_pkg;
  localparam int DATA_W = 16;
  localparam int SLOTS = 4;
  localparam int PTR_W = 4;
  localparam int CNT_W = 5;
  // Register indices on the processor port.
  localparam logic [3:0] ADDR_GLOBAL = 4'h0;
  localparam logic [3:0] ADDR_RX_SC = 4'h1;
  localparam logic [3:0] ADDR_TX_SC = 4'h2;
  localparam logic [3:0] ADDR_RX_DATA = 4'h3;
  localparam logic [3:0] ADDR_TX_DATA = 4'h4;
  localparam logic [3:0] ADDR_DMA_MASK = 4'h5;
  localparam logic [3:0] ADDR_RX_DMA_BASE = 4'h8;
  localparam logic [3:0] ADDR_TX_DMA_BASE = 4'hC;
  // Status and control field positions, shared by both directions.
  localparam int FLAG_LEVEL_BIT = 0;
  localparam int STICKY_BIT = 3;
  localparam int SLOT_EN_LSB = 4;
  localparam int DMA_SEL_LSB = 8;
  localparam int WARN_LSB = 12;
  // Global control and mask field positions.
  localparam int GLB_EN_BIT = 0;
  localparam int GLB_ERRIE_BIT = 1;
  localparam int GLB_LAST_SLOT_LSB = 2;
  localparam int MASK_TX_LSB = 4;
  // Reset values and FIFO count levels.
  localparam logic [15:0] RX_SC_RESET = 16'h0004;
  localparam logic [15:0] TX_SC_RESET = 16'hF003;
  localparam logic [3:0] RX_WARN_RESET = 4'h0;
  localparam logic [3:0] TX_WARN_RESET = 4'hF;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [CNT_W-1:0] CNT_NEAR_FULL = 5'h0F;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [15:0] wdata;
  } cpu_req_t;

  typedef struct packed {
    logic [1:0] slot;
    logic [15:0] data;
  } slot_word_t;

  // Entries held, using the last-access-was-write flag on equal pointers.
  function automatic logic [CNT_W-1:0] fifo_count(input logic [PTR_W-1:0] wp,
                                                  input logic [PTR_W-1:0] rp,
                                                  input logic lastw);
    if (wp == rp) begin
      return lastw ? 5'h10 : 5'h00;
    end
    return {1'b0, PTR_W'(wp - rp)};
  endfunction
endpackage

/* rtl/audio_link.sv */
// Serial slot engine on the codec bit clock.
// Assumes frame sync and receive data change with the bit clock.
`timescale 1ns/1ps
`default_nettype none
module audio_link (
  input wire logic bit_clk_in,
  input wire logic rstn_in,
  input wire logic frame_sync_in,
  input wire logic serial_rx_in,
  input wire logic [3:0] rx_slot_en_in,
  input wire logic [3:0] tx_slot_en_in,
  input wire logic [1:0] last_slot_in,
  input wire logic [3:0][15:0] tx_stage_in,
  output logic rx_toggle_out,
  output audio_pkg::slot_word_t rx_word_out,
  output logic tx_toggle_out,
  output logic [1:0] tx_slot_out,
  output logic serial_tx_out,
  output logic serial_tx_oe_n_out
);
  logic rst_meta_q, lrst_n_q;
  logic [9:0] cfg_meta_q, cfg_q;
  logic [5:0] pos_q;
  logic [5:0] pos;
  logic [15:0] rx_sh_q, tx_sh_q, load_word;
  logic rx_ok, tx_ok;

  always_ff @(posedge bit_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_meta_q <= 1'b0;
      lrst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      lrst_n_q <= rst_meta_q;
    end
  end

  // Slot configuration is quasi-static and crosses as synchronised levels.
  always_ff @(posedge bit_clk_in or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      cfg_meta_q <= 10'h000;
      cfg_q <= 10'h000;
    end else begin
      cfg_meta_q <= {last_slot_in, tx_slot_en_in, rx_slot_en_in};
      cfg_q <= cfg_meta_q;
    end
  end

  always_comb begin
    pos = frame_sync_in ? 6'h00 : 6'(pos_q + 6'h01);
    rx_ok = cfg_q[pos[5:4]] && (pos[5:4] <= cfg_q[9:8]);
    tx_ok = cfg_q[4 + pos[5:4]] && (pos[5:4] <= cfg_q[9:8]);
    load_word = tx_stage_in[pos[5:4]];
  end

  always_ff @(posedge bit_clk_in or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      pos_q <= 6'h3F;
      rx_sh_q <= 16'h0000;
      rx_toggle_out <= 1'b0;
      rx_word_out <= '0;
    end else begin
      pos_q <= pos;
      rx_sh_q <= {rx_sh_q[14:0], serial_rx_in};
      if (pos[3:0] == 4'hF && rx_ok) begin
        rx_word_out <= {pos[5:4], rx_sh_q[14:0], serial_rx_in};
        rx_toggle_out <= !rx_toggle_out;
      end
    end
  end

  // The load event tells the core the slot word is taken, so it may restage.
  // A slot's first bit is launched on the edge that opens the slot, so the codec
  // takes each bit on the following falling edge and no frame length is guessed.
  always_ff @(posedge bit_clk_in or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      tx_sh_q <= 16'h0000;
      serial_tx_out <= 1'b0;
      serial_tx_oe_n_out <= 1'b1;
      tx_toggle_out <= 1'b0;
      tx_slot_out <= 2'b00;
    end else if (pos[3:0] == 4'h0) begin
      serial_tx_out <= load_word[15];
      tx_sh_q <= {load_word[14:0], 1'b0};
      serial_tx_oe_n_out <= !tx_ok;
      if (tx_ok) begin
        tx_slot_out <= pos[5:4];
        tx_toggle_out <= !tx_toggle_out;
      end
    end else begin
      serial_tx_out <= tx_sh_q[15];
      tx_sh_q <= {tx_sh_q[14:0], 1'b0};
    end
  end
endmodule
`default_nettype wire

/* tb/audio_codec_model.sv */
// Behavioural codec on the far side of the serial audio link.
// Assumes the bench calls its tasks and the block samples on the rising bit clock.
`timescale 1ns/1ps
`default_nettype none
module audio_codec_model (
  output logic bit_clk_out,
  output logic frame_sync_out,
  output logic serial_rx_out,
  input wire logic serial_tx_in,
  input wire logic serial_tx_oe_n_in
);
  logic [1:0][15:0] tx_words;
  int driven;
  initial begin
    bit_clk_out = 1'b0;
    frame_sync_out = 1'b0;
    serial_rx_out = 1'b0;
  end
  // The bit clock runs only while a task is active and stands still in between.
  task automatic run(input int n);
    repeat (n) begin
      #3 bit_clk_out = 1'b1;
      #3 bit_clk_out = 1'b0;
    end
  endtask
  task automatic frame(input logic [1:0][15:0] w);
    driven = 0;
    #1.3;
    run(4);
    for (int i = 0; i < 32; i++) begin
      frame_sync_out = (i == 0);
      serial_rx_out = w[i/16][15-i%16];
      #3 bit_clk_out = 1'b1;
      // The block launches each bit on the rising edge; it is taken before the fall.
      #3;
      if (serial_tx_oe_n_in === 1'b0) begin
        tx_words[i/16][15-i%16] = serial_tx_in;
        driven++;
      end
      bit_clk_out = 1'b0;
    end
    // A released data line shows the inverse of its last bit.
    serial_rx_out = ~serial_rx_out;
    frame_sync_out = 1'b0;
  endtask
endmodule
`default_nettype wire

/* tb/audio_rx_tx_fifo_slot_control_tb.sv */
// Self-checking bench for the audio slot FIFO block.
// Assumes the codec model in tb/ and the shared audio package.
`timescale 1ns/1ps
`default_nettype none
module audio_rx_tx_fifo_slot_control_tb;
  logic ref_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  audio_pkg::cpu_req_t req = '0;
  logic [15:0] rdata;
  logic bclk, fs, srx, stx, stx_oe_n, rx_irq, rx_err, tx_irq;
  logic [3:0] rx_dma, tx_dma;
  int failures = 0;
  int samples_checked = 0;
  always #4 ref_clk_in = ~ref_clk_in;
  audio_rx_tx_fifo_slot_control u_dut (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
    .cpu_req_in(req), .cpu_rdata_out(rdata), .bit_clk_in(bclk), .frame_sync_in(fs),
    .serial_rx_in(srx), .serial_transmit_output_out(stx), .serial_transmit_oe_n_out(stx_oe_n),
    .rx_irq_out(rx_irq), .rx_err_irq_out(rx_err), .tx_irq_out(tx_irq),
    .rx_dma_req_out(rx_dma), .tx_dma_req_out(tx_dma));
  audio_codec_model u_codec (.bit_clk_out(bclk), .frame_sync_out(fs), .serial_rx_out(srx),
    .serial_tx_in(stx), .serial_tx_oe_n_in(stx_oe_n));
  task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s exp %h got %h", n, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk_in);
    #1 req = {1'b1, 1'b0, a, d};
    @(posedge ref_clk_in);
    #1 req = '0;
  endtask
  task automatic rc(input logic [3:0] a, input logic [15:0] exp);
    @(posedge ref_clk_in);
    #1 req = {1'b0, 1'b1, a, 16'h0000};
    @(posedge ref_clk_in);
    #1 req = '0;
    chk($sformatf("reg %h", a), rdata, exp);
  endtask
  task automatic fr(input logic [15:0] s1, input logic [15:0] s0);
    u_codec.frame({s1, s0});
    repeat (12) @(posedge ref_clk_in);
  endtask
  task automatic close_out();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rc(audio_pkg::ADDR_RX_SC, 16'h0004);
    rc(audio_pkg::ADDR_TX_SC, 16'hF003);
    chk("tx_irq", {15'h0000, tx_irq}, 16'h0001);
    rc(4'h6, 16'h0000);
    wr(audio_pkg::ADDR_RX_SC, 16'h0003);
    rc(audio_pkg::ADDR_RX_SC, 16'h0004);
  endtask
  task automatic t_rx();
    wr(audio_pkg::ADDR_GLOBAL, 16'h0007);
    wr(audio_pkg::ADDR_RX_SC, 16'h2030);
    fr(16'hA011, 16'hA010);
    rc(audio_pkg::ADDR_RX_SC, 16'h2031);
    chk("rx_irq", {15'h0000, rx_irq}, 16'h0000);
    fr(16'hA021, 16'hA020);
    chk("rx_irq", {15'h0000, rx_irq}, 16'h0001);
    for (int f = 3; f <= 8; f++) begin
      fr(16'(16'hA001 | (f << 4)), 16'(16'hA000 | (f << 4)));
    end
    rc(audio_pkg::ADDR_RX_SC, 16'h2032);
    fr(16'hBAD1, 16'hBAD0);
    rc(audio_pkg::ADDR_RX_SC, 16'h203A);
    chk("rx_err", {15'h0000, rx_err}, 16'h0001);
    for (int f = 1; f <= 8; f++) begin
      for (int s = 0; s < 2; s++) begin
        rc(audio_pkg::ADDR_RX_DATA, 16'(16'hA000 | (f << 4) | s));
      end
    end
    rc(audio_pkg::ADDR_RX_SC, 16'h203C);
    wr(audio_pkg::ADDR_RX_SC, 16'h2038);
    chk("rx_err", {15'h0000, rx_err}, 16'h0000);
  endtask
  task automatic t_dma();
    wr(audio_pkg::ADDR_DMA_MASK, 16'h0022);
    wr(audio_pkg::ADDR_RX_SC, 16'h0630);
    fr(16'hB001, 16'hB000);
    chk("rx_dma", {12'h000, rx_dma}, 16'h0002);
    rc(audio_pkg::ADDR_RX_DMA_BASE + 4'h1, 16'hB001);
    chk("rx_dma", {12'h000, rx_dma}, 16'h0000);
    chk("rx_irq", {15'h0000, rx_irq}, 16'h0001);
    rc(audio_pkg::ADDR_RX_DATA, 16'hB000);
  endtask
  task automatic t_tx();
    wr(audio_pkg::ADDR_TX_SC, 16'h1230);
    chk("tx_dma", {12'h000, tx_dma}, 16'h0002);
    wr(audio_pkg::ADDR_TX_DMA_BASE + 4'h1, 16'hC0DE);
    chk("tx_dma", {12'h000, tx_dma}, 16'h0000);
    for (int k = 0; k < 3; k++) begin
      wr(audio_pkg::ADDR_TX_DATA, 16'(16'hC100 + k));
    end
    rc(audio_pkg::ADDR_TX_SC, 16'h1230);
    chk("tx_irq", {15'h0000, tx_irq}, 16'h0000);
    fr(16'h0000, 16'h0000);
    chk("driven", 16'(u_codec.driven), 16'h0020);
    fr(16'h0000, 16'h0000);
    chk("tx0", u_codec.tx_words[0], 16'hC100);
    chk("tx1", u_codec.tx_words[1], 16'hC0DE);
    rc(audio_pkg::ADDR_TX_SC, 16'h1231);
    chk("tx_irq", {15'h0000, tx_irq}, 16'h0001);
    fr(16'h0000, 16'h0000);
    rc(audio_pkg::ADDR_TX_SC, 16'h1233);
    fr(16'h0000, 16'h0000);
    fr(16'h0000, 16'h0000);
    chk("tx0", u_codec.tx_words[0], 16'hC102);
    rc(audio_pkg::ADDR_TX_SC, 16'h123B);
    wr(audio_pkg::ADDR_TX_SC, 16'h1018);
    fr(16'h0000, 16'h0000);
    chk("driven", 16'(u_codec.driven), 16'h0010);
    wr(audio_pkg::ADDR_RX_SC, 16'h0000);
    wr(audio_pkg::ADDR_TX_SC, 16'h1008);
    fr(16'h0000, 16'h0000);
    wr(audio_pkg::ADDR_GLOBAL, 16'h0000);
    chk("oe_n", {15'h0000, stx_oe_n}, 16'h0001);
    for (int k = 0; k < 16; k++) begin
      wr(audio_pkg::ADDR_TX_DATA, 16'(16'hD000 + k));
    end
    rc(audio_pkg::ADDR_TX_SC, 16'h1004);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    fork
      u_codec.run(6);
      repeat (6) @(posedge ref_clk_in);
    join
    #1 rstn_in = 1'b1;
    t_reset();
    t_rx();
    t_dma();
    t_tx();
    close_out();
  end
  initial begin
    #200000;
    failures++;
    close_out();
  end
endmodule
`default_nettype wire
